/* File: hdl/fractional_vector_multiply.sv */
// Purpose: Execute stage for four saturating vector multiply instructions
// Assumes: Operands arrive with the instruction in the same cycle
// Notes: One cycle latency, one instruction accepted every cycle
// Notes on behaviour
// - Right multiply: low signed halves, shift one
// - Left multiply: upper signed halves, shift one
// - Both operands minus one clamp to maximum
// - Fractional saturation sets overflow flag bit
// - Accumulator zero undefined, others untouched
// - Left bytes times halves into halves
// - Right bytes times halves into halves
// - Zero-extended product, saturate to all ones
// - Either lane saturating sets overflow flag
// - Absent or disabled extension raises exception
// - No operand dependent exceptions at all
// - Decode major group, mode bit, fields
`timescale 1ns/1ns
module fractional_vector_multiply (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic issue_valid,
	input wire logic [31:0] instr_word,
	input wire logic [31:0] first_source_value,
	input wire logic [31:0] second_source_value,
	input wire logic dsp_present,
	input wire logic dsp_enable,
	input wire logic flag_clear,
	output fvm_pkg::writeback_t writeback,
	output fvm_pkg::exc_t exception,
	output logic flag_set,
	output logic ouflag21,
	output logic acc0_undefined
);
	fvm_pkg::state_t state;
	fvm_pkg::state_t next_state;
	fvm_pkg::op_t op;
	logic [5:0] major;
	logic [9:0] minor;
	logic [4:0] dest_field;
	logic byte_left;
	logic signed [15:0] frac_a;
	logic signed [15:0] frac_b;
	logic signed [31:0] frac_prod;
	logic frac_clamp;
	logic [31:0] frac_result;
	logic [15:0] lane_product [2];
	logic [1:0] lane_sat;
	logic [31:0] byte_result;
	logic is_frac;
	logic executes;

	// Decode
	always_comb begin
		major = instr_word[fvm_pkg::MAJOR_LSB +: 6];
		minor = instr_word[fvm_pkg::MINOR_LSB +: 10];
		dest_field = instr_word[fvm_pkg::DEST_LSB +: 5];
		op = fvm_pkg::OP_NONE;
		if (major == fvm_pkg::MAJOR_OPCODE_GROUP &&
			!instr_word[fvm_pkg::MODE_BIT]) begin
			unique case (minor)
				fvm_pkg::MINOR_FRAC_LEFT: op = fvm_pkg::OP_FRAC_LEFT;
				fvm_pkg::MINOR_FRAC_RIGHT: op = fvm_pkg::OP_FRAC_RIGHT;
				fvm_pkg::MINOR_BYTE_LEFT: op = fvm_pkg::OP_BYTE_LEFT;
				fvm_pkg::MINOR_BYTE_RIGHT: op = fvm_pkg::OP_BYTE_RIGHT;
				default: op = fvm_pkg::OP_NONE;
			endcase
		end
		is_frac = (op == fvm_pkg::OP_FRAC_LEFT) ||
			(op == fvm_pkg::OP_FRAC_RIGHT);
		byte_left = (op == fvm_pkg::OP_BYTE_LEFT);
	end

	// Fractional Q15 by Q15 into Q31
	always_comb begin
		if (op == fvm_pkg::OP_FRAC_LEFT) begin
			frac_a = first_source_value[31:16];
			frac_b = second_source_value[31:16];
		end else begin
			frac_a = first_source_value[15:0];
			frac_b = second_source_value[15:0];
		end
		frac_prod = frac_a * frac_b;
		frac_clamp = (frac_a == fvm_pkg::Q15_MINUS_ONE) &&
			(frac_b == fvm_pkg::Q15_MINUS_ONE);
		// The only product that cannot shift left without overflow
		frac_result = frac_clamp ? fvm_pkg::Q31_MAX :
			{frac_prod[30:0], 1'b0};
	end

	// Byte lanes: lane 1 feeds the upper result half
	for (genvar i = 0; i < 2; i++) begin : g_lane
		logic [7:0] lane_byte;
		always_comb begin
			if (byte_left) begin
				lane_byte = first_source_value[16 + 8 * i +: 8];
			end else begin
				lane_byte = first_source_value[8 * i +: 8];
			end
		end
		byte_half_mul u_mul (
			.byte_in(lane_byte),
			.half_in(second_source_value[16 * i +: 16]),
			.product(lane_product[i]),
			.saturated(lane_sat[i])
		);
	end

	assign byte_result = {lane_product[1], lane_product[0]};

	// Exceptions gate execution; no operand value can raise one
	assign executes = issue_valid && (op != fvm_pkg::OP_NONE) &&
		dsp_present && dsp_enable;

	always_comb begin
		next_state = state;
		next_state.wb.valid = 1'b0;
		next_state.exc = '0;
		next_state.flag_set = 1'b0;
		next_state.acc0_undefined = 1'b0;
		if (issue_valid && op != fvm_pkg::OP_NONE) begin
			if (!dsp_present) begin
				next_state.exc.reserved_instr = 1'b1;
			end else if (!dsp_enable) begin
				next_state.exc.dsp_disabled = 1'b1;
			end else begin
				next_state.wb.valid = 1'b1;
				next_state.wb.dest = dest_field;
				// Accumulator zero may be overwritten by the shared multiplier
				next_state.acc0_undefined = 1'b1;
				if (is_frac) begin
					next_state.wb.data = frac_result;
					next_state.flag_set = frac_clamp;
				end else begin
					next_state.wb.data = byte_result;
					next_state.flag_set = |lane_sat;
				end
			end
		end
		if (flag_clear) begin
			next_state.ouflag21 = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (next_state.flag_set) begin
			next_state.ouflag21 = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state.wb.valid <= 1'b0;
			state.wb.dest <= fvm_pkg::DEST_RESET;
			state.wb.data <= fvm_pkg::DATA_RESET;
			state.exc <= '0;
			state.flag_set <= 1'b0;
			state.ouflag21 <= fvm_pkg::OUFLAG_RESET;
			state.acc0_undefined <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign writeback = state.wb;
	assign exception = state.exc;
	assign flag_set = state.flag_set;
	assign ouflag21 = state.ouflag21;
	assign acc0_undefined = state.acc0_undefined;

	// Reference models used only by the checks below
	function automatic logic [15:0] ref_u8u16(input logic [7:0] b,
		input logic [15:0] h);
		logic [23:0] p;
		p = 24'(b) * 24'(h);
		return (p[23:16] != 8'h00) ? 16'hffff : p[15:0];
	endfunction

	function automatic logic [31:0] ref_q15(input logic [15:0] a,
		input logic [15:0] b);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		return (a == 16'h8000 && b == 16'h8000) ? 32'h7fffffff :
			{p[30:0], 1'b0};
	endfunction

	function automatic logic u8u16_sat(input logic [7:0] b,
		input logic [15:0] h);
		logic [23:0] p;
		p = 24'(b) * 24'(h);
		return p[23:16] != 8'h00;
	endfunction

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	a_frac_right_calc: assert property (
		executes && op == fvm_pkg::OP_FRAC_RIGHT |=>
		writeback.valid && writeback.data ==
		ref_q15($past(first_source_value[15:0]),
		$past(second_source_value[15:0])))
		else $error("right fractional product wrong");

	a_frac_left_calc: assert property (
		executes && op == fvm_pkg::OP_FRAC_LEFT |=>
		writeback.valid && writeback.data ==
		ref_q15($past(first_source_value[31:16]),
		$past(second_source_value[31:16])))
		else $error("left fractional product wrong");

	a_frac_clamp_value: assert property (
		executes && is_frac && frac_clamp |=>
		writeback.data == 32'h7fffffff && flag_set)
		else $error("minus one squared not clamped");

	a_frac_flag_set: assert property (
		executes && is_frac |=> flag_set == $past(frac_clamp))
		else $error("fractional flag set mismatch");

	a_acc0_marked: assert property (
		acc0_undefined == writeback.valid)
		else $error("accumulator zero marking wrong");

	a_byte_left_lanes: assert property (
		executes && op == fvm_pkg::OP_BYTE_LEFT |=>
		writeback.data[31:16] == ref_u8u16($past(first_source_value[31:24]),
		$past(second_source_value[31:16])) &&
		writeback.data[15:0] == ref_u8u16($past(first_source_value[23:16]),
		$past(second_source_value[15:0])))
		else $error("left byte lanes wrong");

	a_byte_right_lanes: assert property (
		executes && op == fvm_pkg::OP_BYTE_RIGHT |=>
		writeback.data[31:16] == ref_u8u16($past(first_source_value[15:8]),
		$past(second_source_value[31:16])) &&
		writeback.data[15:0] == ref_u8u16($past(first_source_value[7:0]),
		$past(second_source_value[15:0])))
		else $error("right byte lanes wrong");

	a_byte_sat_value: assert property (
		executes && !is_frac && lane_sat[1] |=>
		writeback.data[31:16] == 16'hffff)
		else $error("saturated lane not all ones");

	a_byte_flag_set: assert property (
		executes && !is_frac |=> flag_set == ($past(u8u16_sat(
		g_lane[0].lane_byte, second_source_value[15:0])) || $past(u8u16_sat(
		g_lane[1].lane_byte, second_source_value[31:16]))))
		else $error("byte flag set mismatch");

	a_absent_reserved: assert property (
		issue_valid && op != fvm_pkg::OP_NONE && !dsp_present |=>
		exception.reserved_instr && !exception.dsp_disabled &&
		!writeback.valid)
		else $error("absent extension not trapped");

	a_disabled_trap: assert property (
		issue_valid && op != fvm_pkg::OP_NONE && dsp_present && !dsp_enable
		|=> exception.dsp_disabled && !writeback.valid && !flag_set)
		else $error("disabled extension not trapped");

	a_no_data_exc: assert property (
		executes |=> exception == '0)
		else $error("operand dependent exception");

	a_decode_dest: assert property (
		executes ##1 writeback.valid |->
		writeback.dest == $past(instr_word[15:11]))
		else $error("destination field wrong");

	a_decode_reject: assert property (
		issue_valid && instr_word[fvm_pkg::MODE_BIT] |=>
		!writeback.valid && exception == '0)
		else $error("mode bit one accepted");

	a_flag_sticky: assert property (
		ouflag21 && !flag_clear |=> ouflag21)
		else $error("overflow flag lost");

	a_flag_source: assert property (
		$rose(ouflag21) |-> flag_set)
		else $error("overflow flag set without saturation");

	// A clear with no instruction behind it must always take effect
	a_flag_clear: assert property (
		flag_clear && !executes |=> !ouflag21)
		else $error("overflow flag not cleared");

	a_flag_follows_set: assert property (
		flag_set |-> ouflag21)
		else $error("saturation did not reach the flag");

	a_byte_sat_low: assert property (
		executes && !is_frac && lane_sat[0] |=>
		writeback.data[15:0] == 16'hffff)
		else $error("saturated low lane not all ones");

	a_exc_single: assert property (
		!(exception.reserved_instr && exception.dsp_disabled))
		else $error("both exceptions raised together");

	// Saturation only ever shows up beside a register write
	a_flag_with_wb: assert property (
		flag_set |-> writeback.valid)
		else $error("flag pulse without writeback");

	a_idle_quiet: assert property (
		!executes |=> !writeback.valid && !flag_set && !acc0_undefined)
		else $error("idle slot produced a result");

	a_dest_hold: assert property (
		!executes |=> writeback.dest == $past(writeback.dest))
		else $error("destination changed without an instruction");

	c_frac_clamp: cover property (executes && is_frac && frac_clamp);
	c_byte_sat: cover property (executes && !is_frac && lane_sat == 2'b11);
	c_set_over_clear: cover property (flag_clear && next_state.flag_set);
	c_disabled: cover property (exception.dsp_disabled);
	c_back_to_back: cover property (writeback.valid [*3]);

endmodule // fractional_vector_multiply

/* File: hdl/fvm_pkg.sv */
// Purpose: Constants and types for the fractional vector multiply datapath
// Assumes: 32-bit instruction word and 32-bit general register values
// Notes: The datapath takes opcode values and saturation constants from here only
package fvm_pkg;

	// Instruction word layout
	localparam int MAJOR_LSB = 26;
	localparam int SECOND_SRC_LSB = 21;
	localparam int FIRST_SRC_LSB = 16;
	localparam int DEST_LSB = 11;
	localparam int MODE_BIT = 10;
	localparam int MINOR_LSB = 0;

	localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h00;
	localparam logic [9:0] MINOR_FRAC_LEFT = 10'h025;
	localparam logic [9:0] MINOR_FRAC_RIGHT = 10'h065;
	localparam logic [9:0] MINOR_BYTE_LEFT = 10'h095;
	localparam logic [9:0] MINOR_BYTE_RIGHT = 10'h0d5;

	// Saturation values
	localparam logic [15:0] Q15_MINUS_ONE = 16'h8000;
	localparam logic [31:0] Q31_MAX = 32'h7fffffff;
	localparam logic [15:0] U16_MAX = 16'hffff;

	// Overflow flag position inside the DSP control register
	localparam int OUFLAG_BIT = 21;

	// Reset values
	localparam logic [31:0] DATA_RESET = 32'h00000000;
	localparam logic [4:0] DEST_RESET = 5'h00;
	localparam logic OUFLAG_RESET = 1'b0;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_FRAC_LEFT,
		OP_FRAC_RIGHT,
		OP_BYTE_LEFT,
		OP_BYTE_RIGHT
	} op_t;

	typedef struct packed {
		logic valid;
		logic [4:0] dest;
		logic [31:0] data;
	} writeback_t;

	typedef struct packed {
		logic reserved_instr;
		logic dsp_disabled;
	} exc_t;

	typedef struct packed {
		writeback_t wb;
		exc_t exc;
		logic flag_set;
		logic ouflag21;
		logic acc0_undefined;
	} state_t;

endpackage

/* File: hdl/byte_half_mul.sv */
// Purpose: One lane of unsigned byte by halfword multiply with saturation
// Assumes: Purely combinational, used inside the registered datapath
// Notes: Product is 24 bits wide, so eight discarded bits decide saturation
`timescale 1ns/1ns
module byte_half_mul (
	input wire logic [7:0] byte_in,
	input wire logic [15:0] half_in,
	output logic [15:0] product,
	output logic saturated
);
	logic [23:0] full;

	always_comb begin
		full = 24'(byte_in) * 24'(half_in);
		saturated = (full[23:16] != 8'h00);
		product = saturated ? fvm_pkg::U16_MAX : full[15:0];
	end
endmodule // byte_half_mul

/* File: tb/gpr_model.sv */
// Purpose: General register file beside the multiply datapath
// Assumes: Operands are read combinationally in the issue cycle
// Notes: Accumulators are absent; the datapath must never need them
`timescale 1ns/1ns
module gpr_model (
	input wire logic sys_clk,
	input wire logic [31:0] instr_word,
	input fvm_pkg::writeback_t writeback,
	output logic [31:0] first_source_value,
	output logic [31:0] second_source_value
);
	logic [31:0] regs [32];
	// Bench loads only well-formed operands
	assign first_source_value = regs[instr_word[20:16]];
	assign second_source_value = regs[instr_word[25:21]];
	// Accumulator zero is never read back after a multiply
	always @(posedge sys_clk) begin
		if (writeback.valid === 1'b1) begin
			regs[writeback.dest] <= writeback.data;
		end
	end
endmodule // gpr_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the fractional vector multiply
// Assumes: One cycle latency, back-to-back issue allowed
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module tb;
	typedef struct packed {
		logic [9:0] minor;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] res;
		logic sat;
	} row_t;
	localparam int N = 10;
	row_t rows [N];
	logic [9:0] minors [4] = '{10'h025, 10'h065, 10'h095, 10'h0d5};
	logic [31:0] odd_words [4];
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic issue_valid = 1'b0;
	logic [31:0] instr_word = 32'h00000000;
	logic [31:0] first_source_value;
	logic [31:0] second_source_value;
	logic dsp_present = 1'b1;
	logic dsp_enable = 1'b1;
	logic flag_clear = 1'b0;
	fvm_pkg::writeback_t writeback;
	fvm_pkg::exc_t exception;
	logic flag_set;
	logic ouflag21;
	logic acc0_undefined;
	logic exp_flag = 1'b0;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;

	always #5 sys_clk = ~sys_clk;

	fractional_vector_multiply dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
		.issue_valid(issue_valid), .instr_word(instr_word),
		.first_source_value(first_source_value),
		.second_source_value(second_source_value),
		.dsp_present(dsp_present), .dsp_enable(dsp_enable),
		.flag_clear(flag_clear), .writeback(writeback),
		.exception(exception), .flag_set(flag_set), .ouflag21(ouflag21),
		.acc0_undefined(acc0_undefined));
	gpr_model rf_u (.sys_clk(sys_clk), .instr_word(instr_word),
		.writeback(writeback), .first_source_value(first_source_value),
		.second_source_value(second_source_value));

	function automatic logic [31:0] word(input logic [9:0] m,
		input logic [4:0] d);
		return {6'h00, 5'h02, 5'h01, d, 1'b0, m};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
		end
	endtask

	task automatic drive(input logic v, fc, pe, en,
		input logic [31:0] w, a, b);
		rf_u.regs[1] = a;
		rf_u.regs[2] = b;
		instr_word = w;
		issue_valid = v;
		flag_clear = fc;
		dsp_present = pe;
		dsp_enable = en;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic outcome(input logic v, input logic [4:0] d,
		input logic [31:0] data, input logic sat, input logic [1:0] exc);
		check(writeback.valid, v);
		if (v) begin
			check(writeback.dest, d);
		end
		check(writeback.data, data);
		check(flag_set, sat);
		check(acc0_undefined, v);
		check(exception, exc);
		check(ouflag21, exp_flag);
	endtask

	task automatic conclude();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Generous ceiling; the whole run needs well under a hundred cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 1000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		rows = '{
			'{10'h065, 32'h00004000, 32'h00004000, 32'h20000000, 1'b0},
			'{10'h065, 32'h00008000, 32'h00008000, 32'h7fffffff, 1'b1},
			'{10'h025, 32'h80000000, 32'h40000000, 32'hc0000000, 1'b0},
			'{10'h025, 32'h80001234, 32'h80000001, 32'h7fffffff, 1'b1},
			'{10'h065, 32'h7fff8000, 32'h0001ffff, 32'h00010000, 1'b0},
			'{10'h095, 32'h02030000, 32'h01000010, 32'h02000030, 1'b0},
			'{10'h095, 32'hff010000, 32'h01010005, 32'hffff0005, 1'b0},
			'{10'h095, 32'h01020000, 32'h00018000, 32'h0001ffff, 1'b1},
			'{10'h0d5, 32'haabb0304, 32'h10000100, 32'h30000400, 1'b0},
			'{10'h0d5, 32'h0000ff02, 32'h01020007, 32'hffff000e, 1'b1}};
		odd_words = '{32'h00000425, 32'h04000025, 32'h00000115, 32'h00000065};
		repeat (16) @(posedge sys_clk);
		#1;
		outcome(1'b0, 5'h00, 32'h00000000, 1'b0, 2'b00);
		rst_b = 1'b1;
		// Back-to-back issue, one row per cycle
		for (int i = 0; i < N; i++) begin
			exp_flag = exp_flag | rows[i].sat;
			drive(1'b1, 1'b0, 1'b1, 1'b1, word(rows[i].minor, 5'(i + 3)),
				rows[i].a, rows[i].b);
			outcome(1'b1, 5'(i + 3), rows[i].res, rows[i].sat, 2'b00);
		end
		// Set wins over a clear in the same cycle, then a lone clear
		drive(1'b1, 1'b1, 1'b1, 1'b1, word(10'h065, 5'h14),
			32'h00008000, 32'h00008000);
		outcome(1'b1, 5'h14, 32'h7fffffff, 1'b1, 2'b00);
		exp_flag = 1'b0;
		drive(1'b0, 1'b1, 1'b1, 1'b1, 32'h00000000, 32'h0, 32'h0);
		outcome(1'b0, 5'h00, 32'h7fffffff, 1'b0, 2'b00);
		// Absent then disabled extension; saturating operands must not leak
		for (int k = 0; k < 8; k++) begin
			// Absence wins whatever the enable says
			drive(1'b1, 1'b0, k >= 4, k[0] && k < 4,
				word(minors[k % 4], 5'h05), 32'h80808080, 32'h80008000);
			outcome(1'b0, 5'h00, 32'h7fffffff, 1'b0,
				(k < 4) ? 2'b10 : 2'b01);
		end
		// Foreign words and an idle issue slot do nothing
		for (int k = 0; k < 4; k++) begin
			drive(k < 3, 1'b0, 1'b1, 1'b1, odd_words[k],
				32'h00008000, 32'h00008000);
			outcome(1'b0, 5'h00, 32'h7fffffff, 1'b0, 2'b00);
		end
		// Reset again in mid-run
		exp_flag = 1'b1;
		drive(1'b1, 1'b0, 1'b1, 1'b1, word(10'h0d5, 5'h06),
			32'h0000ff02, 32'h01020007);
		outcome(1'b1, 5'h06, 32'hffff000e, 1'b1, 2'b00);
		rst_b = 1'b0;
		exp_flag = 1'b0;
		drive(1'b0, 1'b0, 1'b1, 1'b1, 32'h00000000, 32'h0, 32'h0);
		outcome(1'b0, 5'h00, 32'h00000000, 1'b0, 2'b00);
		// Release again; the first request is taken at the next edge
		rst_b = 1'b1;
		drive(1'b1, 1'b0, 1'b1, 1'b1, word(10'h025, 5'h07),
			32'h40000000, 32'h40000000);
		outcome(1'b1, 5'h07, 32'h20000000, 1'b0, 2'b00);
		check(rf_u.regs[3], rows[0].res);
		conclude();
	end
endmodule // tb
